//--- hw/wake_pkg.sv
package wake_pkg;
    // Clock rate and documented times
    localparam int CLK_MHZ = 10;
    localparam int SHORT_FILTER_US = 16;
    localparam int LONG_FILTER_US = 64;
    localparam int TICK_US = 10;
    localparam int FILT_W = 10;
    localparam logic [FILT_W-1:0] SHORT_FILTER_CYC = FILT_W'(SHORT_FILTER_US * CLK_MHZ);
    localparam logic [FILT_W-1:0] LONG_FILTER_CYC = FILT_W'(LONG_FILTER_US * CLK_MHZ);
    localparam logic [6:0] TICK_LAST = 7'(TICK_US * CLK_MHZ - 1);

    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int N_WAKE = 3;
    localparam int N_AUX = 2;
    localparam int N_SRC = N_WAKE + N_AUX;

    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_WAKE_EN = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_PULL = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_FILTER = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_TMR_A = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_TMR_B = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_SRC_STAT = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_ALT_STAT = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_LEVEL = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h9;

    // Field positions
    localparam int AUX_EN_LSB = 3;
    localparam int TMR_PERIOD_LSB = 8;

    // Reset values
    localparam logic [DATA_W-1:0] WAKE_EN_RST = 16'h0000;
    localparam logic [DATA_W-1:0] PULL_RST = 16'h0000;
    localparam logic [DATA_W-1:0] FILTER_RST = 16'h0000;
    localparam logic [DATA_W-1:0] TMR_RST = 16'h0a02;
    localparam logic [DATA_W-1:0] IRQ_MASK_RST = 16'h0000;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_STOP = 2'b01,
        MODE_SLEEP = 2'b10,
        MODE_FAILSAFE = 2'b11
    } dev_mode_e;

    typedef enum logic [1:0] {
        FLT_STATIC_SHORT = 2'b00,
        FLT_STATIC_LONG = 2'b01,
        FLT_CYCLIC_A = 2'b10,
        FLT_CYCLIC_B = 2'b11
    } filter_cfg_e;

    typedef enum logic [1:0] {
        PULL_NONE = 2'b00,
        PULL_DOWN = 2'b01,
        PULL_UP = 2'b10,
        PULL_AUTO = 2'b11
    } pull_sel_e;

    typedef enum logic {
        FLT_IDLE = 1'b0,
        FLT_QUALIFY = 1'b1
    } filter_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
endpackage : wake_pkg

//--- hw/wake_filter.sv
`timescale 1ns/1ps
`default_nettype none
module wake_filter
    import wake_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic en_i,
    input wire logic level_i,
    input wire logic [FILT_W-1:0] limit_i,
    output logic level_o,
    output logic event_o
);
    filter_state_e state_reg;
    logic [FILT_W-1:0] cnt_reg;
    logic level_reg;
    logic primed_reg;
    logic event_reg;

    // First level after reset is taken without an event
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            primed_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            primed_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_reg <= FLT_IDLE;
            cnt_reg <= '0;
            level_reg <= 1'b0;
            event_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            event_reg <= 1'b0;
            if (!primed_reg)
            begin
                level_reg <= level_i;
            end
            else
            begin
                case (state_reg)
                    FLT_IDLE:
                    begin
                        cnt_reg <= '0;
                        if (en_i && level_i != level_reg)
                        begin
                            state_reg <= FLT_QUALIFY;
                            cnt_reg <= 10'h001;
                        end
                    end
                    FLT_QUALIFY:
                    begin
                        if (!en_i || level_i == level_reg)
                        begin
                            state_reg <= FLT_IDLE;
                            cnt_reg <= '0;
                        end
                        else if (cnt_reg >= limit_i)
                        begin
                            // Both directions give an event
                            state_reg <= FLT_IDLE;
                            cnt_reg <= '0;
                            level_reg <= level_i;
                            event_reg <= 1'b1;
                        end
                        else
                        begin
                            cnt_reg <= cnt_reg + 10'h001;
                        end
                    end
                    default:
                    begin
                        state_reg <= FLT_IDLE;
                        cnt_reg <= '0;
                    end
                endcase
            end
        end
    end

    assign level_o = level_reg;
    assign event_o = event_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_filter_accept: assert property (ce_i && primed_reg && state_reg == FLT_QUALIFY
        && en_i && level_i != level_reg && cnt_reg >= limit_i
        |=> event_reg && level_reg == $past(level_i))
        else $error("filter did not accept a held level");
    a_glitch_drop: assert property (ce_i && state_reg == FLT_QUALIFY
        && level_i == level_reg |=> !event_reg && state_reg == FLT_IDLE)
        else $error("glitch was not dropped");
    a_event_changes_level: assert property (ce_i && primed_reg
        |=> event_reg == (level_reg != $past(level_reg)))
        else $error("level changed without event");
    c_rise: cover property (event_reg && level_reg);
    c_fall: cover property (event_reg && !level_reg);
endmodule : wake_filter
`default_nettype wire

//--- hw/wake_input_detector.sv
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module wake_input_detector
    import wake_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire reg_req_s bus_i,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic [N_WAKE-1:0] hv_wake_input_i,
    input wire logic [N_AUX-1:0] aux_output_pins_i,
    input wire dev_mode_e mode_i,
    output logic irq_o,
    output logic wake_req_o,
    output logic [N_WAKE-1:0] pull_up_o,
    output logic [N_WAKE-1:0] pull_down_o
);
    function automatic logic [FILT_W-1:0] filter_limit(input logic [1:0] cfg);
        filter_limit = (cfg == FLT_STATIC_LONG) ? LONG_FILTER_CYC : SHORT_FILTER_CYC;
    endfunction : filter_limit

    function automatic logic sense_active(input logic [1:0] cfg, input logic [1:0] win);
        case (cfg)
            FLT_CYCLIC_A: sense_active = win[0];
            FLT_CYCLIC_B: sense_active = win[1];
            default: sense_active = 1'b1;
        endcase
    endfunction : sense_active

    // Returns {pull_up, pull_down}
    function automatic logic [1:0] pull_decode(input logic [1:0] sel, input logic level);
        case (sel)
            PULL_DOWN: pull_decode = 2'b01;
            PULL_UP: pull_decode = 2'b10;
            PULL_AUTO: pull_decode = level ? 2'b10 : 2'b01;
            default: pull_decode = 2'b00;
        endcase
    endfunction : pull_decode

    function automatic logic wr_hit(input reg_req_s req, input logic [ADDR_W-1:0] addr);
        wr_hit = req.wr && req.addr == addr;
    endfunction : wr_hit

    logic [DATA_W-1:0] wake_enable_control_reg;
    logic [DATA_W-1:0] pull_source_control_reg;
    logic [DATA_W-1:0] filter_mode_control_reg;
    logic [DATA_W-1:0] cyclic_timer_a_control_reg;
    logic [DATA_W-1:0] cyclic_timer_b_control_reg;
    logic [N_WAKE-1:0] wake_source_status_reg;
    logic [N_WAKE-1:0] wake_source_status_next;
    logic [N_AUX-1:0] alt_pin_wake_status_reg;
    logic [N_AUX-1:0] alt_pin_wake_status_next;
    logic [N_SRC-1:0] irq_status_reg;
    logic [N_SRC-1:0] irq_status_next;
    logic [N_SRC-1:0] irq_mask_reg;
    logic [N_SRC-1:0] sync1_reg;
    logic [N_SRC-1:0] sync2_reg;
    logic [6:0] tick_cnt_reg;
    logic [7:0] phase_reg [2];
    logic [1:0] window_reg;
    logic [N_SRC-1:0] flt_level;
    logic [N_SRC-1:0] flt_event;
    logic [N_WAKE-1:0] level_view;
    logic [N_WAKE-1:0] src_hit;
    logic [N_AUX-1:0] aux_hit;
    logic active_mode;
    logic tick;
    logic [DATA_W-1:0] tmr_ctrl [2];

    // Pins cross into the clock domain
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else if (ce_i)
        begin
            sync1_reg <= {aux_output_pins_i, hv_wake_input_i};
            sync2_reg <= sync1_reg;
        end
    end

    // Configuration registers
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            wake_enable_control_reg <= WAKE_EN_RST;
            pull_source_control_reg <= PULL_RST;
            filter_mode_control_reg <= FILTER_RST;
            cyclic_timer_a_control_reg <= TMR_RST;
            cyclic_timer_b_control_reg <= TMR_RST;
            irq_mask_reg <= IRQ_MASK_RST[N_SRC-1:0];
        end
        else if (ce_i)
        begin
            if (wr_hit(bus_i, ADDR_WAKE_EN))
            begin
                wake_enable_control_reg <= {11'h000, bus_i.wdata[4:0]};
            end
            if (wr_hit(bus_i, ADDR_PULL))
            begin
                pull_source_control_reg <= {10'h000, bus_i.wdata[5:0]};
            end
            if (wr_hit(bus_i, ADDR_FILTER))
            begin
                filter_mode_control_reg <= {10'h000, bus_i.wdata[5:0]};
            end
            if (wr_hit(bus_i, ADDR_TMR_A))
            begin
                cyclic_timer_a_control_reg <= bus_i.wdata;
            end
            if (wr_hit(bus_i, ADDR_TMR_B))
            begin
                cyclic_timer_b_control_reg <= bus_i.wdata;
            end
            if (wr_hit(bus_i, ADDR_IRQ_MASK))
            begin
                irq_mask_reg <= bus_i.wdata[N_SRC-1:0];
            end
        end
    end

    assign tmr_ctrl[0] = cyclic_timer_a_control_reg;
    assign tmr_ctrl[1] = cyclic_timer_b_control_reg;
    assign tick = (tick_cnt_reg == TICK_LAST);

    // Shared prescaler for both cyclic timers
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            tick_cnt_reg <= '0;
        end
        else if (ce_i)
        begin
            tick_cnt_reg <= tick ? 7'h00 : tick_cnt_reg + 7'h01;
        end
    end

    // Cyclic timers: window open while phase below on-time
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            phase_reg[0] <= '0;
            phase_reg[1] <= '0;
            window_reg <= '0;
        end
        else if (ce_i)
        begin
            for (int t = 0; t < 2; t++)
            begin
                if (tick)
                begin
                    if (phase_reg[t] + 8'h01 >= tmr_ctrl[t][TMR_PERIOD_LSB +: 8])
                    begin
                        phase_reg[t] <= '0;
                    end
                    else
                    begin
                        phase_reg[t] <= phase_reg[t] + 8'h01;
                    end
                end
                window_reg[t] <= phase_reg[t] < tmr_ctrl[t][7:0];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < N_WAKE; g++)
        begin : g_wake
            wake_filter u_filter (
                .clk_i(clk_i),
                .srst_i(srst_i),
                .ce_i(ce_i),
                .en_i(sense_active(filter_mode_control_reg[2*g +: 2], window_reg)),
                .level_i(sync2_reg[g]),
                .limit_i(filter_limit(filter_mode_control_reg[2*g +: 2])),
                .level_o(flt_level[g]),
                .event_o(flt_event[g])
            );
            // Cyclic sense reports the sample held by the filter
            assign level_view[g] = filter_mode_control_reg[2*g+1] ? flt_level[g] : sync2_reg[g];
        end
        for (g = 0; g < N_AUX; g++)
        begin : g_aux
            wake_filter u_filter (
                .clk_i(clk_i),
                .srst_i(srst_i),
                .ce_i(ce_i),
                .en_i(1'b1),
                .level_i(sync2_reg[N_WAKE+g]),
                .limit_i(SHORT_FILTER_CYC),
                .level_o(flt_level[N_WAKE+g]),
                .event_o(flt_event[N_WAKE+g])
            );
        end
    endgenerate

    assign src_hit = flt_event[N_WAKE-1:0] & wake_enable_control_reg[N_WAKE-1:0];
    assign aux_hit = flt_event[N_SRC-1:N_WAKE] & wake_enable_control_reg[AUX_EN_LSB +: N_AUX];
    assign active_mode = (mode_i == MODE_NORMAL) || (mode_i == MODE_STOP);

    // Sticky flags: set wins over write-one clear
    always_comb
    begin
        wake_source_status_next = wake_source_status_reg;
        alt_pin_wake_status_next = alt_pin_wake_status_reg;
        irq_status_next = irq_status_reg;
        if (wr_hit(bus_i, ADDR_SRC_STAT))
        begin
            wake_source_status_next = wake_source_status_next & ~bus_i.wdata[N_WAKE-1:0];
        end
        if (wr_hit(bus_i, ADDR_ALT_STAT))
        begin
            alt_pin_wake_status_next = alt_pin_wake_status_next & ~bus_i.wdata[N_AUX-1:0];
        end
        if (wr_hit(bus_i, ADDR_IRQ_STAT))
        begin
            irq_status_next = irq_status_next & ~bus_i.wdata[N_SRC-1:0];
        end
        wake_source_status_next = wake_source_status_next | src_hit;
        alt_pin_wake_status_next = alt_pin_wake_status_next | aux_hit;
        if (active_mode)
        begin
            irq_status_next = irq_status_next | {aux_hit, src_hit};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            wake_source_status_reg <= '0;
            alt_pin_wake_status_reg <= '0;
            irq_status_reg <= '0;
        end
        else if (ce_i)
        begin
            wake_source_status_reg <= wake_source_status_next;
            alt_pin_wake_status_reg <= alt_pin_wake_status_next;
            irq_status_reg <= irq_status_next;
        end
    end

    // Interrupt and wake request outputs
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            irq_o <= 1'b0;
            wake_req_o <= 1'b0;
        end
        else if (ce_i)
        begin
            irq_o <= |(irq_status_next & irq_mask_reg);
            wake_req_o <= !active_mode && (|{aux_hit, src_hit});
        end
    end

    // Pull current source controls
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            pull_up_o <= '0;
            pull_down_o <= '0;
        end
        else if (ce_i)
        begin
            for (int i = 0; i < N_WAKE; i++)
            begin
                {pull_up_o[i], pull_down_o[i]} <=
                    pull_decode(pull_source_control_reg[2*i +: 2], flt_level[i]);
            end
        end
    end

    // Read data, zero for unmapped offsets
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rdata_o <= '0;
        end
        else if (ce_i)
        begin
            rdata_o <= '0;
            if (bus_i.rd)
            begin
                case (bus_i.addr)
                    ADDR_WAKE_EN: rdata_o <= wake_enable_control_reg;
                    ADDR_PULL: rdata_o <= pull_source_control_reg;
                    ADDR_FILTER: rdata_o <= filter_mode_control_reg;
                    ADDR_TMR_A: rdata_o <= cyclic_timer_a_control_reg;
                    ADDR_TMR_B: rdata_o <= cyclic_timer_b_control_reg;
                    ADDR_SRC_STAT: rdata_o <= {13'h0000, wake_source_status_reg};
                    ADDR_ALT_STAT: rdata_o <= {14'h0000, alt_pin_wake_status_reg};
                    ADDR_LEVEL: rdata_o <= {13'h0000, level_view};
                    ADDR_IRQ_STAT: rdata_o <= {11'h000, irq_status_reg};
                    ADDR_IRQ_MASK: rdata_o <= {11'h000, irq_mask_reg};
                    default: rdata_o <= '0;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_flag_sticky: assert property (ce_i |=> ((($past(wake_source_status_reg)
        & ~($past(bus_i.wr && bus_i.addr == ADDR_SRC_STAT) ? $past(bus_i.wdata[2:0]) : 3'h0))
        & ~wake_source_status_reg) == 3'h0))
        else $error("wake source flag lost without a clear");
    a_flag_set_wins: assert property (ce_i && src_hit[0] |=> wake_source_status_reg[0])
        else $error("wake source flag not set by event");
    a_disabled_quiet: assert property (ce_i && flt_event[2] && !wake_enable_control_reg[2]
        && !wake_source_status_reg[2] |=> !wake_source_status_reg[2])
        else $error("disabled input set a wake flag");
    a_wake_in_sleep: assert property (ce_i && !active_mode && |src_hit
        |=> wake_req_o && (irq_status_reg & ~$past(irq_status_reg)) == '0)
        else $error("no wake request in low power mode");
    a_irq_in_normal: assert property (ce_i && active_mode && src_hit[0]
        && irq_mask_reg[0] |=> irq_o && irq_status_reg[0] && !wake_req_o)
        else $error("no interrupt in active mode");
    a_aux_status: assert property (ce_i && aux_hit[0] |=> alt_pin_wake_status_reg[0]
        && !wake_source_status_reg[0] == !$past(wake_source_status_next[0]))
        else $error("aux pin event not flagged");
    a_static_level: assert property (ce_i && filter_mode_control_reg[1] == 1'b0
        && bus_i.rd && bus_i.addr == ADDR_LEVEL |=> rdata_o[0] == $past(sync2_reg[0]))
        else $error("static level not live");
    a_cyclic_hold: assert property (ce_i && filter_mode_control_reg[1:0] == FLT_CYCLIC_A
        && !window_reg[0] ##1 ce_i && filter_mode_control_reg[1:0] == FLT_CYCLIC_A
        |-> $stable(level_view[0]))
        else $error("cyclic level moved outside window");
    a_pull_auto: assert property (ce_i && pull_source_control_reg[5:4] == PULL_AUTO
        |=> pull_up_o[2] == $past(flt_level[2]) && pull_down_o[2] == !$past(flt_level[2]))
        else $error("automatic pull does not follow level");
    a_pull_none: assert property (ce_i && pull_source_control_reg[1:0] == PULL_NONE
        |=> !pull_up_o[0] && !pull_down_o[0])
        else $error("pull active with code none");
    c_cyclic_wake: cover property (filter_mode_control_reg[1] && wake_req_o);
    c_irq: cover property (irq_o);
    c_aux: cover property (alt_pin_wake_status_reg != 2'b00);
endmodule : wake_input_detector
`default_nettype wire

//--- test/wake_switches.sv
`timescale 1ns/1ps
`default_nettype none
module wake_switches
    import wake_pkg::*;
(
    input wire logic [N_WAKE-1:0] closed_i,
    input wire logic [N_WAKE-1:0] level_i,
    input wire logic [N_WAKE-1:0] pull_up_i,
    input wire logic [N_WAKE-1:0] pull_down_i,
    output logic [N_WAKE-1:0] pin_o
);
    // Open switch: pull source wins, else the board ties the pin low
    always_comb
    begin
        for (int k = 0; k < N_WAKE; k++)
        begin
            if (closed_i[k])
                pin_o[k] = level_i[k];
            else
                pin_o[k] = pull_up_i[k] & ~pull_down_i[k];
        end
    end
endmodule : wake_switches
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import wake_pkg::*;
;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce = 1'b1;
    reg_req_s bus = '0;
    logic [DATA_W-1:0] rdata;
    logic [N_WAKE-1:0] sw_en = '1;
    logic [N_WAKE-1:0] sw_lvl = '0;
    logic [N_WAKE-1:0] pin;
    logic [N_WAKE-1:0] pu;
    logic [N_WAKE-1:0] pd;
    logic [N_AUX-1:0] aux = '0;
    dev_mode_e mode = MODE_NORMAL;
    logic irq;
    logic wake_req;
    int n_fail = 0;
    int n_checks = 0;
    int n_wake = 0;
    int k;

    always #50 clk_i = ~clk_i;
    always @(posedge clk_i)
        if (wake_req === 1'b1)
            n_wake <= n_wake + 1;

    wake_switches i_wake_switches (.closed_i(sw_en), .level_i(sw_lvl),
        .pull_up_i(pu), .pull_down_i(pd), .pin_o(pin));
    wake_input_detector i_wake_input_detector (.clk_i(clk_i), .srst_i(srst_i),
        .ce_i(ce), .bus_i(bus), .rdata_o(rdata), .hv_wake_input_i(pin),
        .aux_output_pins_i(aux), .mode_i(mode), .irq_o(irq),
        .wake_req_o(wake_req), .pull_up_o(pu), .pull_down_o(pd));

    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus.wr <= 1'b0;
    endtask : wr
    task rdc(input string what, input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_i);
        bus.rd <= 1'b0;
        #1;
        check(what, rdata, exp);
    endtask : rdc
    task clr;
        wr(ADDR_IRQ_STAT, 16'h001f);
        wr(ADDR_SRC_STAT, 16'h0007);
    endtask : clr
    task waitc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : waitc
    task complete_run;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    task t_reset;
        rdc("enable", ADDR_WAKE_EN, WAKE_EN_RST);
        rdc("pull", ADDR_PULL, PULL_RST);
        rdc("filter", ADDR_FILTER, FILTER_RST);
        rdc("timer a", ADDR_TMR_A, TMR_RST);
        rdc("timer b", ADDR_TMR_B, TMR_RST);
        rdc("mask", ADDR_IRQ_MASK, IRQ_MASK_RST);
        rdc("source", ADDR_SRC_STAT, 16'h0000);
        rdc("unmapped", 4'hf, 16'h0000);
        check("pulls", 16'({pu, pd}), 16'h0000);
        @(posedge clk_i);
        ce <= 1'b0;
        wr(ADDR_WAKE_EN, 16'h001f);
        ce <= 1'b1;
        rdc("frozen", ADDR_WAKE_EN, 16'h0000);
        $display("done reset");
    endtask : t_reset
    task t_static;
        wr(ADDR_IRQ_MASK, 16'h001f);
        wr(ADDR_WAKE_EN, 16'h0003);
        sw_lvl <= 3'b111;
        waitc(50);
        sw_lvl <= 3'b101;
        waitc(300);
        rdc("source", ADDR_SRC_STAT, 16'h0001);
        check("irq", 16'(irq), 16'h0001);
        rdc("level", ADDR_LEVEL, 16'h0005);
        rdc("irq stat", ADDR_IRQ_STAT, 16'h0001);
        wr(ADDR_IRQ_MASK, 16'h0000);
        clr();
        sw_lvl <= 3'b100;
        waitc(180);
        rdc("irq stat", ADDR_IRQ_STAT, 16'h0001);
        check("masked irq", 16'(irq), 16'h0000);
        wr(ADDR_IRQ_MASK, 16'h0001);
        waitc(2);
        check("irq", 16'(irq), 16'h0001);
        clr();
        waitc(2);
        check("irq", 16'(irq), 16'h0000);
        rdc("source", ADDR_SRC_STAT, 16'h0000);
        $display("done static");
    endtask : t_static
    task t_long;
        wr(ADDR_FILTER, 16'h0004);
        sw_lvl <= 3'b110;
        waitc(300);
        sw_lvl <= 3'b100;
        waitc(700);
        rdc("long glitch", ADDR_SRC_STAT, 16'h0000);
        sw_lvl <= 3'b110;
        waitc(700);
        rdc("long edge", ADDR_SRC_STAT, 16'h0002);
        $display("done long");
    endtask : t_long
    task t_pull;
        wr(ADDR_WAKE_EN, 16'h0007);
        wr(ADDR_PULL, 16'h0039);
        waitc(4);
        check("pulls", 16'({pu, pd}), 16'h0031);
        sw_lvl <= 3'b010;
        waitc(180);
        check("auto pulls", 16'({pu, pd}), 16'h0015);
        $display("done pull");
    endtask : t_pull
    task t_sleep;
        clr();
        mode <= MODE_SLEEP;
        k = n_wake;
        sw_lvl <= 3'b011;
        waitc(180);
        check("wake pulses", 16'(n_wake - k), 16'h0001);
        rdc("irq stat", ADDR_IRQ_STAT, 16'h0000);
        rdc("source", ADDR_SRC_STAT, 16'h0001);
        mode <= MODE_FAILSAFE;
        k = n_wake;
        sw_lvl <= 3'b010;
        waitc(180);
        check("fail-safe wake", 16'(n_wake - k), 16'h0001);
        rdc("irq stat", ADDR_IRQ_STAT, 16'h0000);
        mode <= MODE_STOP;
        wr(ADDR_WAKE_EN, 16'h0008);
        aux <= 2'b01;
        waitc(180);
        rdc("alt stat", ADDR_ALT_STAT, 16'h0001);
        rdc("irq stat", ADDR_IRQ_STAT, 16'h0008);
        $display("done sleep aux");
    endtask : t_sleep
    task t_cyclic;
        wr(ADDR_TMR_A, 16'h0a05);
        wr(ADDR_FILTER, 16'h0002);
        wr(ADDR_WAKE_EN, 16'h0001);
        clr();
        mode <= MODE_SLEEP;
        k = n_wake;
        sw_lvl <= 3'b011;
        waitc(1200);
        rdc("cyclic", ADDR_SRC_STAT, 16'h0001);
        check("cyclic wake", 16'(n_wake - k), 16'h0001);
        rdc("sampled", ADDR_LEVEL, 16'h0003);
        wr(ADDR_TMR_A, 16'h0a00);
        clr();
        sw_lvl <= 3'b010;
        waitc(200);
        rdc("held sample", ADDR_LEVEL, 16'h0003);
        rdc("closed window", ADDR_SRC_STAT, 16'h0000);
        $display("done cyclic");
    endtask : t_cyclic

    initial
    begin
        waitc(8);
        srst_i <= 1'b0;
        waitc(4);
        t_reset();
        t_static();
        t_long();
        t_pull();
        t_sleep();
        t_cyclic();
        complete_run();
    end
    initial
    begin
        #2000000;
        n_fail++;
        complete_run();
    end
endmodule : tb
`default_nettype wire
